// ### dac_port_consts.vh
// Purpose: shared constants for the dac serial control port
// Assumes: 16-bit frames, msb first: rw bit, 7-bit address, 8-bit data
// Notes: definitions only
`ifndef DAC_PORT_CONSTS_VH
`define DAC_PORT_CONSTS_VH
`define FRAME_BITS 16
`define ADDR_BITS 7
`define DATA_BITS 8
`define NUM_CH 6
// address map of the internal registers
`define ADDR_STATUS 7'h00
`define ADDR_CH_HI_BASE 7'h10
`define ADDR_CH_LO_BASE 7'h20
// reset values
`define CODE_RESET 14'h0000
`define STATUS_RESET 8'h00
`endif

// ### edge_sync.v
// Purpose: two-flop synchroniser with rise and fall pulses
// Assumes: input is asynchronous to ref_clk
// Notes: first flop is read only by the second
module edge_sync #(
	parameter RESET_VAL = 1'b0
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// async input and synced outputs
	input wire async_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// meta flop, sync flop, then an edge history flop
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
			prev_q <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule

// ### dac_serial_control_port.v
// Purpose: serial control port of a six-channel dac: frames, registers, load and alert
// Assumes: serial clock at most 10 MHz so 50 MHz sampling sees every edge
// Notes: frame = rw(1=read), addr[6:0], data[7:0]; read data returns in the same frame
// Notes: load held low: a written byte reaches the dac register at frame end
// Functional notes
// - sample data in on serial clock rising
// - readback data changes on serial clock falling
// - alert falls when status register changes
// - alert held until host reads status
// - load low pulse copies pending inputs together
// - reset input restores every register default
`include "dac_port_consts.vh"
module dac_serial_control_port #(
	parameter NUM_CH = `NUM_CH,
	parameter CODE_W = 14
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// serial link pins
	input wire cs_n,
	input wire sclk,
	input wire sdi,
	output reg sdo,
	output wire sdo_oe,
	// control pins
	input wire dac_load_strobe_n,
	output wire alarm_n,
	// status sources from the analog side
	input wire [7:0] status_in,
	// dac register contents toward the converters
	output reg [NUM_CH*CODE_W-1:0] dac_code,
	output reg dac_update
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	wire cs_lvl, cs_rise, cs_fall;
	wire sclk_rise, sclk_fall;
	wire sdi_lvl;
	wire ld_lvl, ld_fall;

	edge_sync #(.RESET_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(cs_n),
		.level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
	// only the edges of sclk are used; its level output is left open
	edge_sync #(.RESET_VAL(1'b0)) u_sclk (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(sclk),
		.level(), .rise(sclk_rise), .fall(sclk_fall));
	// sdi sampled with the same latency as sclk so setup is preserved
	edge_sync #(.RESET_VAL(1'b0)) u_sdi (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(sdi),
		.level(sdi_lvl), .rise(), .fall());
	edge_sync #(.RESET_VAL(1'b1)) u_ld (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(dac_load_strobe_n),
		.level(ld_lvl), .rise(), .fall(ld_fall));

	// ****************************************
	// shift engine
	// ****************************************
	reg [`FRAME_BITS-1:0] shift_q;
	reg [4:0] bit_cnt_q;
	reg rd_q;
	reg [`ADDR_BITS-1:0] addr_q;
	reg [7:0] tx_q;
	reg wr_pend_q;
	reg [7:0] status_q;
	reg alarm_q;
	reg [CODE_W-1:0] in_reg [0:NUM_CH-1];
	reg [NUM_CH-1:0] new_q;
	wire in_frame = ~cs_lvl;
	// the count stops at a full frame, so surplus clocks change nothing
	wire frame_full = (bit_cnt_q == 5'd`FRAME_BITS);
	wire [`FRAME_BITS-1:0] shift_nx = {shift_q[`FRAME_BITS-2:0], sdi_lvl};

	// one-hot channel match of an address against one byte bank
	function [NUM_CH-1:0] chan_hit;
		input [`ADDR_BITS-1:0] a;
		input [`ADDR_BITS-1:0] base;
		integer n;
		begin
			chan_hit = {NUM_CH{1'b0}};
			for (n = 0; n < NUM_CH; n = n + 1)
				chan_hit[n] = (a == base + n[`ADDR_BITS-1:0]);
		end
	endfunction

	// channel selects of the frame that just closed
	wire [NUM_CH-1:0] hi_sel = chan_hit(addr_q, `ADDR_CH_HI_BASE);
	wire [NUM_CH-1:0] lo_sel = chan_hit(addr_q, `ADDR_CH_LO_BASE);

	// register read decode, used at address phase
	function [7:0] read_mux;
		input [`ADDR_BITS-1:0] a;
		input [7:0] st;
		input [NUM_CH*CODE_W-1:0] codes;
		integer k;
		begin
			read_mux = 8'h00;
			if (a == `ADDR_STATUS)
				read_mux = st;
			for (k = 0; k < NUM_CH; k = k + 1) begin
				if (a == `ADDR_CH_HI_BASE + k[6:0])
					read_mux = {2'b00, codes[k*CODE_W+8 +: 6]};
				if (a == `ADDR_CH_LO_BASE + k[6:0])
					read_mux = codes[k*CODE_W +: 8];
			end
		end
	endfunction

	// the sdo driver owns the pin only inside a frame
	// outside a frame the pin is released and its level is don't-care
	assign sdo_oe = in_frame;

	// bit counter, shift register and outbound byte
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= 16'h0000;
			bit_cnt_q <= 5'h00;
			rd_q <= 1'b0;
			addr_q <= 7'h00;
			tx_q <= 8'h00;
			sdo <= 1'b0;
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= 1'b0;
			if (cs_fall) begin
				bit_cnt_q <= 5'h00;
				sdo <= 1'b0;
			end else if (in_frame && sclk_rise && !frame_full) begin
				shift_q <= shift_nx;
				bit_cnt_q <= bit_cnt_q + 5'd1;
				if (bit_cnt_q == 5'd7) begin
					rd_q <= shift_nx[7];
					addr_q <= shift_nx[6:0];
					tx_q <= read_mux(shift_nx[6:0], status_q, dac_code);
				end
			end else if (in_frame && sclk_fall && rd_q && bit_cnt_q >= 5'd8 && !frame_full) begin
				// data byte leaves msb first, launched on falling edges
				sdo <= tx_q[7];
				tx_q <= {tx_q[6:0], 1'b0};
			end
			// a short frame is dropped; only a full one commits
			// the synced edge trails the pin by two cycles; the host idles longer
			if (cs_rise && frame_full && !rd_q)
				wr_pend_q <= 1'b1;
		end
	end

	// ****************************************
	// input registers, dac registers, load
	// ****************************************
	integer i;
	// load fall moves pending inputs; held low, frame end does it
	// the load synchroniser resets high, so a pin tied low gives one fall
	// just after reset; nothing is pending then, so it moves nothing
	wire load_now = ld_fall | (wr_pend_q & ~ld_lvl);

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < NUM_CH; i = i + 1)
				in_reg[i] <= `CODE_RESET;
			new_q <= {NUM_CH{1'b0}};
			dac_code <= {NUM_CH{`CODE_RESET}};
			dac_update <= 1'b0;
		end else begin
			dac_update <= 1'b0;
			if (load_now) begin
				for (i = 0; i < NUM_CH; i = i + 1)
					if (new_q[i])
						dac_code[i*CODE_W +: CODE_W] <= in_reg[i];
				dac_update <= |new_q;
				new_q <= {NUM_CH{1'b0}};
			end
			// with load high a write only marks its channel pending;
			// with load low it goes straight to the dac register as well
			if (wr_pend_q) begin
				for (i = 0; i < NUM_CH; i = i + 1) begin
					if (hi_sel[i]) begin
						in_reg[i][CODE_W-1:8] <= shift_q[CODE_W-9:0];
						new_q[i] <= ld_lvl;
						if (!ld_lvl) begin
							dac_code[i*CODE_W +: CODE_W] <= {shift_q[CODE_W-9:0], in_reg[i][7:0]};
							dac_update <= 1'b1;
						end
					end
					if (lo_sel[i]) begin
						in_reg[i][7:0] <= shift_q[7:0];
						new_q[i] <= ld_lvl;
						if (!ld_lvl) begin
							dac_code[i*CODE_W +: CODE_W] <= {in_reg[i][CODE_W-1:8], shift_q[7:0]};
							dac_update <= 1'b1;
						end
					end
				end
			end
		end
	end

	// ****************************************
	// status and alert
	// ****************************************
	// status_in already runs on the core clock, so it needs no synchroniser
	// status read completes when a read frame of the status address closes
	wire status_read = cs_rise & frame_full & rd_q & (addr_q == `ADDR_STATUS);
	// the registered copy turns each change into a one-cycle difference

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `STATUS_RESET;
			alarm_q <= 1'b0;
		end else begin
			status_q <= status_in;
			// a change in the same cycle as the read keeps the alert set
			if (status_in != status_q)
				alarm_q <= 1'b1;
			else if (status_read)
				alarm_q <= 1'b0;
		end
	end

	assign alarm_n = ~alarm_q;
endmodule

// ### dac_port_assertions.sv
// Purpose: port checks of the dac control port
// Assumes: pins synced in two core cycles
// Notes: bound to the top module
module dac_port_chk #(
	parameter NUM_CH = 6,
	parameter CODE_W = 14
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// serial link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe,
	// control and status
	input wire logic dac_load_strobe_n,
	input wire logic alarm_n,
	input wire logic [7:0] status_in,
	// dac registers
	input wire logic [NUM_CH*CODE_W-1:0] dac_code,
	input wire logic dac_update
);
	timeunit 1ns / 1ps;
	// the first edge only starts the reset; values sampled there predate it
	logic past_first_q = 1'b0;
	always @(posedge ref_clk) past_first_q <= 1'b1;
	// one domain, so clock and disable are set once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_set; $changed(status_in) |=> !alarm_n; endproperty
	a_set: assert property (p_set) else $error("alarm late");
	property p_hold; (!alarm_n && cs_n) [*8] |=> !alarm_n; endproperty
	a_hold: assert property (p_hold) else $error("alarm dropped");
	property p_rst; disable iff (1'b0) past_first_q && !rst_n |-> alarm_n && dac_code == '0 && !sdo_oe && !sdo && !dac_update; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_code; $changed(dac_code) |-> dac_update; endproperty
	a_code: assert property (p_code) else $error("silent load");
	property p_load; dac_update |-> !$past(dac_load_strobe_n, 2) || !$past(dac_load_strobe_n, 4); endproperty
	a_load: assert property (p_load) else $error("stray load");
	property p_sdo; $changed(sdo) && $past(sdo_oe) && !cs_n |-> !sclk; endproperty
	a_sdo: assert property (p_sdo) else $error("sdo on rise");
	property p_oe; $stable(cs_n) [*3] |-> sdo_oe == !cs_n; endproperty
	a_oe: assert property (p_oe) else $error("sdo enable");
endmodule
bind dac_serial_control_port dac_port_chk #(.NUM_CH(NUM_CH), .CODE_W(CODE_W)) i_dac_port_chk (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.cs_n(cs_n),
	.sclk(sclk),
	.sdo(sdo),
	.sdo_oe(sdo_oe),
	.dac_load_strobe_n(dac_load_strobe_n),
	.alarm_n(alarm_n),
	.status_in(status_in),
	.dac_code(dac_code),
	.dac_update(dac_update)
);

// ### dac_host_model.sv
// Purpose: host end of the serial link
// Assumes: 20 ns core clock, 160 ns sclk
// Notes: sclk stands low between frames
module dac_host_model (
	// core clock and data from the device
	input wire logic ref_clk,
	input wire logic sdo,
	// link drive
	output logic cs_n = 1'b1,
	output logic sclk = 1'b0,
	output logic sdi = 1'b0
);
	timeunit 1ns / 1ps;
	// n msb bits of w; 6.25 MHz suits reads and writes alike
	task automatic frame(input logic [15:0] w, input int n, output logic [7:0] rd);
		@(posedge ref_clk) cs_n <= 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			@(posedge ref_clk) sdi <= w[i];
			repeat (3) @(posedge ref_clk);
			sclk <= 1'b1;
			if (i < 8) rd[i] = sdo;
			repeat (4) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
		sdi <= ~sdi; // released line shows no stale bit
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

// ### dac_serial_control_port_test.sv
// Purpose: self-checking bench of the dac control port
// Assumes: 50 MHz core clock, host model on the link
// Notes: load held low until the strobe case and left high from then on
module dac_serial_control_port_test;
	timeunit 1ns / 1ps;
	logic ref_clk = 1'b0, rst_n = 1'b0, dac_load_strobe_n = 1'b0, cs_n, sclk, sdi, sdo, sdo_oe, alarm_n, dac_update;
	logic [7:0] status_in = 8'h00, rd;
	logic [83:0] dac_code, exp_code = '0;
	logic [13:0] codes [6] = '{14'h3fff, 14'h0001, 14'h2aaa, 14'h1555, 14'h2000, 14'h1fff};
	int fail_count = 0, n_tests = 0;
	int n_upd = 0;
	dac_serial_control_port i_dac_serial_control_port (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.dac_load_strobe_n(dac_load_strobe_n),
		.alarm_n(alarm_n),
		.status_in(status_in),
		.dac_code(dac_code),
		.dac_update(dac_update)
	);
	dac_host_model i_dac_host_model (
		.ref_clk(ref_clk),
		.sdo(sdo),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdi(sdi)
	);
	// dac register loads seen so far
	always @(posedge ref_clk) if (dac_update === 1'b1) n_upd <= n_upd + 1;
	initial forever #10 ref_clk = ~ref_clk;
	// guard: the sequence needs about 2600 cycles
	initial begin
		repeat (8000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
	task automatic chk(input logic [83:0] got, exp);
		n_tests++;
		if (got !== exp) fail_count++;
		if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic give_verdict;
		if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_dac_host_model.frame({1'b0, a, d}, 16, rd);
		repeat (6) @(posedge ref_clk);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// rows: each code through both bytes, load tied low
		for (int k = 0; k < 6; k++) begin
			wr(7'h10 + 7'(k), {2'b00, codes[k][13:8]});
			wr(7'h20 + 7'(k), codes[k][7:0]);
			exp_code[k*14 +: 14] = codes[k];
			chk(dac_code, exp_code);
		end
		chk(n_upd, 12);
		i_dac_host_model.frame(16'h2077, 15, rd);
		wr(7'h00, 8'hff);
		chk(dac_code, exp_code);
		// load high: two channels wait for one strobe
		dac_load_strobe_n <= 1'b1;
		wr(7'h20, 8'h11);
		wr(7'h25, 8'h22);
		chk(dac_code, exp_code);
		dac_load_strobe_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		dac_load_strobe_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		exp_code[7:0] = 8'h11;
		exp_code[77:70] = 8'h22;
		chk(dac_code, exp_code);
		chk(n_upd, 13);
		// alarm holds until the status read
		status_in <= 8'h5a;
		repeat (40) @(posedge ref_clk);
		chk(alarm_n, 1'b0);
		i_dac_host_model.frame(16'h8000, 16, rd);
		repeat (4) @(posedge ref_clk);
		chk(rd, 8'h5a);
		chk(alarm_n, 1'b1);
		// a read of another register leaves a new alert standing
		status_in <= 8'h3c;
		i_dac_host_model.frame(16'ha500, 16, rd);
		chk(rd, 8'h22);
		chk(alarm_n, 1'b0);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		chk(dac_code, '0);
		chk({sdo, sdo_oe, alarm_n, dac_update}, 4'b0010);
		give_verdict();
	end
endmodule
